// >>> conv_defines.svh
// constants for the converter output demux and control block
// Behaviour
// - extended control overrides swing, edge, range pins
// - normal range pin high 800, low 600
// - extended range programmable from 560 to 840
// - sample on both input clock edges
// - default four lanes at half clock rate
// - bit 8 set in ddr gives 1:2
// - without ddr bit 8 selects launch edge
// - lanes ordered by sample time a to d
// - fixed per lane latencies 13 to 14.5
// - data launched on source clock edges, both in ddr, in sdr the edge set by the edge pin or bit 8
// - sampling phase trimmed in background while trim is idle
// - sdr edge high rising, low falling
// - sdr clock equals lane rate, ddr half
// - floating edge pin selects ddr
// - sleep request high drops link_oe to disable the link outputs
// - sleep during trim waits for trim end
// - sleep at power up holds off trim
// - trim request while asleep is discarded
// - trim active high for whole trim
// - offset binary, clamp and flag out of range
`ifndef CONV_DEFINES_SVH
`define CONV_DEFINES_SVH
`define FS_HIGH_MV      10'd800
`define FS_LOW_MV       10'd600
`define FS_EXT_MIN_MV   10'd560
`define FS_EXT_MAX_MV   10'd840
`define TRIM_REQ_CYCLES 8'd80
`define TRIM_LEN_CYCLES 8'd200
`define PWRUP_DLY       16'h0100
`define LAT_RISE_STAGES 14
`define LAT_FALL_STAGES 13
`define CODE_MIN        8'h00
`define CODE_MAX        8'hff
`define BIT_DEMUX       8
`define BIT_SWING       9
`define BIT_NSDR        10
`define PHASE_STEP      6'h01
`endif

// >>> conv_pkg.sv
// types for the converter output demux and control block
package conv_pkg;
    typedef enum logic [3:0] {
        TR_WAIT = 4'b0001,
        TR_RUN  = 4'b0010,
        TR_IDLE = 4'b0100,
        TR_OFF  = 4'b1000
    } trim_state_t;
    typedef enum logic [1:0] {
        EDGE_LOW   = 2'b00,
        EDGE_HIGH  = 2'b01,
        EDGE_FLOAT = 2'b10
    } pin3_t;
endpackage

// >>> lane_sync.sv
// two stage synchroniser for level signals
`timescale 1ns/1ps
`default_nettype none
module lane_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] din,
    output var  logic [W-1:0] dout
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_ff <= '0;
            dout    <= '0;
        end else begin
            meta_ff <= din;
            dout    <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// >>> conv_ctrl.sv
// converter control, trim sequencing and output demux on the link clock
`timescale 1ns/1ps
`default_nettype none
`include "conv_defines.svh"
module conv_ctrl
    import conv_pkg::*;
(
    // system side
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // control pins
    input  wire logic       ext_mode,
    input  wire logic       full_scale_select,
    input  wire logic       output_swing_select,
    input  wire pin3_t      launch_edge_select,
    input  wire logic       sleep_request,
    input  wire logic       trim_request_n,
    // extended register values
    input  wire logic [15:0] cfg_word,
    input  wire logic [9:0] ext_fs_mv,
    // converter cores, on the link clock
    input  wire logic       clk_link,
    input  wire logic [7:0] rise_edge_core,
    input  wire logic [7:0] fall_edge_core,
    input  wire logic       rise_over,
    input  wire logic       rise_under,
    input  wire logic       fall_over,
    input  wire logic       fall_under,
    // status and settings
    output var  logic       trim_active,
    output var  logic [9:0] range_mv,
    output var  logic       swing_high,
    output var  logic       ddr_mode,
    output var  logic       demux_half,
    output var  logic       launch_rise,
    output var  logic [5:0] sample_phase,
    // link outputs
    output var  logic [7:0] lane_a,
    output var  logic [7:0] lane_b,
    output var  logic [7:0] lane_c,
    output var  logic [7:0] lane_d,
    output var  logic       out_range,
    output var  logic       source_sync_clock,
    output var  logic       link_oe
);
    // ==========================================================
    // pin synchronisers
    logic [4:0] pin_s;
    lane_sync #(.W(5)) u_pins (
        .clk   (clk_sys),
        .reset (reset),
        .din   ({sleep_request, trim_request_n, full_scale_select,
                 output_swing_select, ext_mode}),
        .dout  (pin_s)
    );
    logic sleep_s;
    logic req_n_s;
    logic fs_s;
    logic swing_s;
    logic ext_s;
    assign {sleep_s, req_n_s, fs_s, swing_s, ext_s} = pin_s;
    logic [1:0] edge_s;
    lane_sync #(.W(2)) u_edge (
        .clk   (clk_sys),
        .reset (reset),
        .din   (launch_edge_select),
        .dout  (edge_s)
    );
    function automatic logic [9:0] clamp_fs(input logic [9:0] v);
        if (v < `FS_EXT_MIN_MV)
            clamp_fs = `FS_EXT_MIN_MV;
        else if (v > `FS_EXT_MAX_MV)
            clamp_fs = `FS_EXT_MAX_MV;
        else
            clamp_fs = v;
    endfunction
    // ==========================================================
    // settings selection
    logic nxt_ddr;
    logic nxt_bit8;
    always_comb begin
        if (ext_s) begin
            nxt_ddr  = ~cfg_word[`BIT_NSDR];
            nxt_bit8 = cfg_word[`BIT_DEMUX];
        end else begin
            nxt_ddr  = (edge_s == EDGE_FLOAT);
            nxt_bit8 = (edge_s == EDGE_HIGH);
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            range_mv    <= `FS_LOW_MV;
            swing_high  <= 1'b0;
            ddr_mode    <= 1'b0;
            demux_half  <= 1'b0;
            launch_rise <= 1'b0;
        end else begin
            if (ext_s) begin
                range_mv   <= clamp_fs(ext_fs_mv);
                swing_high <= cfg_word[`BIT_SWING];
            end else begin
                range_mv   <= fs_s ? `FS_HIGH_MV : `FS_LOW_MV;
                swing_high <= swing_s;
            end
            ddr_mode    <= nxt_ddr;
            demux_half  <= nxt_ddr & nxt_bit8 & ext_s;
            launch_rise <= ~nxt_ddr & nxt_bit8;
        end
    end
    // ==========================================================
    // trim request detection: 80 low then 80 high
    logic [7:0] lo_cnt_ff;
    logic [7:0] hi_cnt_ff;
    logic       req_ok_ff;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            lo_cnt_ff <= 8'h00;
            hi_cnt_ff <= 8'h00;
            req_ok_ff <= 1'b0;
        end else begin
            req_ok_ff <= 1'b0;
            if (sleep_s) begin
                lo_cnt_ff <= 8'h00;
                hi_cnt_ff <= 8'h00;
            end else if (!req_n_s) begin
                hi_cnt_ff <= 8'h00;
                if (lo_cnt_ff != `TRIM_REQ_CYCLES)
                    lo_cnt_ff <= lo_cnt_ff + 8'h01;
            end else if (lo_cnt_ff == `TRIM_REQ_CYCLES) begin
                if (hi_cnt_ff == `TRIM_REQ_CYCLES - 8'h01) begin
                    req_ok_ff <= 1'b1;
                    lo_cnt_ff <= 8'h00;
                    hi_cnt_ff <= 8'h00;
                end else begin
                    hi_cnt_ff <= hi_cnt_ff + 8'h01;
                end
            end
        end
    end
    // ==========================================================
    // trim sequencer and sleep
    trim_state_t state_ff;
    logic [15:0] dly_ff;
    logic [7:0]  run_ff;
    logic        asleep_ff;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_ff <= TR_WAIT;
            dly_ff   <= 16'h0000;
            run_ff   <= 8'h00;
        end else begin
            unique case (state_ff)
                TR_WAIT: begin
                    if (!sleep_s) begin
                        if (dly_ff == `PWRUP_DLY) begin
                            state_ff <= TR_RUN;
                            run_ff   <= 8'h00;
                        end else begin
                            dly_ff <= dly_ff + 16'h0001;
                        end
                    end
                end
                TR_RUN: begin
                    if (run_ff == `TRIM_LEN_CYCLES - 8'h01)
                        state_ff <= sleep_s ? TR_OFF : TR_IDLE;
                    else
                        run_ff <= run_ff + 8'h01;
                end
                TR_IDLE: begin
                    if (sleep_s) begin
                        state_ff <= TR_OFF;
                    end else if (req_ok_ff) begin
                        state_ff <= TR_RUN;
                        run_ff   <= 8'h00;
                    end
                end
                TR_OFF: begin
                    if (!sleep_s)
                        state_ff <= TR_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            trim_active <= 1'b0;
            asleep_ff   <= 1'b1;
        end else begin
            trim_active <= (state_ff == TR_RUN);
            asleep_ff   <= (state_ff == TR_OFF) ||
                           (state_ff == TR_WAIT && sleep_s);
        end
    end
    // background sampling phase trim, dithers while idle
    logic [5:0] phase_dir_ff;
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            sample_phase <= 6'h00;
            phase_dir_ff <= `PHASE_STEP;
        end else if (state_ff == TR_IDLE) begin
            sample_phase <= sample_phase + phase_dir_ff;
            phase_dir_ff <= ~phase_dir_ff + 6'h01;
        end
    end
    // ==========================================================
    // link domain: settings crossed as levels
    logic [3:0] set_l;
    lane_sync #(.W(4)) u_link (
        .clk   (clk_link),
        .reset (reset),
        // awake crosses, so the synchroniser reset level reads as asleep
        .din   ({~asleep_ff, ddr_mode, demux_half, launch_rise}),
        .dout  (set_l)
    );
    logic l_awake;
    logic l_sleep;
    logic l_ddr;
    logic l_half;
    logic l_rise;
    assign {l_awake, l_ddr, l_half, l_rise} = set_l;
    assign l_sleep = ~l_awake;
    // clamp and flag out of range, offset binary kept as is
    function automatic logic [7:0] fmt(input logic [7:0] c,
                                       input logic ov,
                                       input logic un);
        fmt = ov ? `CODE_MAX : (un ? `CODE_MIN : c);
    endfunction
    // ==========================================================
    // latency pipelines; one link cycle is one input clock
    logic [8:0] rise_pipe [`LAT_RISE_STAGES];
    logic [8:0] fall_pipe [`LAT_FALL_STAGES];
    always_ff @(posedge clk_link) begin
        rise_pipe[0] <= {rise_over | rise_under,
                         fmt(rise_edge_core, rise_over, rise_under)};
        fall_pipe[0] <= {fall_over | fall_under,
                         fmt(fall_edge_core, fall_over, fall_under)};
    end
    genvar g;
    generate
        for (g = 1; g < `LAT_RISE_STAGES; g++) begin : g_rise
            always_ff @(posedge clk_link)
                rise_pipe[g] <= rise_pipe[g-1];
        end
        for (g = 1; g < `LAT_FALL_STAGES; g++) begin : g_fall
            always_ff @(posedge clk_link)
                fall_pipe[g] <= fall_pipe[g-1];
        end
    endgenerate
    // ==========================================================
    // demux and output clock
    logic phase_ff;
    always_ff @(posedge clk_link or posedge reset) begin
        if (reset)
            phase_ff <= 1'b0;
        else
            phase_ff <= ~phase_ff;
    end
    logic [8:0] rise_late;
    logic [8:0] fall_late;
    assign rise_late = rise_pipe[`LAT_RISE_STAGES-1];
    assign fall_late = fall_pipe[`LAT_FALL_STAGES-1];
    logic [8:0] hold_a;
    logic [8:0] hold_b;
    always_ff @(posedge clk_link or posedge reset) begin
        if (reset) begin
            hold_a <= 9'h000;
            hold_b <= 9'h000;
        end else if (!phase_ff) begin
            hold_a <= rise_late;
            hold_b <= fall_late;
        end
    end
    always_ff @(posedge clk_link or posedge reset) begin
        if (reset) begin
            lane_a            <= `CODE_MIN;
            lane_b            <= `CODE_MIN;
            lane_c            <= `CODE_MIN;
            lane_d            <= `CODE_MIN;
            out_range         <= 1'b0;
            source_sync_clock <= 1'b0;
            link_oe           <= 1'b0;
        end else begin
            link_oe <= ~l_sleep;
            if (l_half) begin
                // lanes a and b are idle at zero in 1:2
                lane_a <= `CODE_MIN;
                lane_b <= `CODE_MIN;
                lane_c <= rise_late[7:0];
                lane_d <= fall_late[7:0];
                out_range <= fall_late[8] | rise_late[8];
                source_sync_clock <= ~source_sync_clock;
            end else begin
                if (phase_ff) begin
                    lane_a <= hold_a[7:0];
                    lane_b <= hold_b[7:0];
                    lane_c <= rise_late[7:0];
                    lane_d <= fall_late[7:0];
                    out_range <= hold_a[8] | hold_b[8] |
                                 rise_late[8] | fall_late[8];
                end
                // ddr: clock at half lane rate, data on both edges
                if (l_ddr)
                    source_sync_clock <= phase_ff ?
                        ~source_sync_clock : source_sync_clock;
                else
                    source_sync_clock <= ~(phase_ff ^ l_rise);
            end
        end
    end
    // ==========================================================
    // checks
    a_trim_flag: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == TR_RUN) |=> trim_active)
        else $error("trim active not shown");
    a_sleep_wait: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == TR_RUN) && sleep_s |=> state_ff != TR_OFF ||
        $past(run_ff) == `TRIM_LEN_CYCLES - 8'h01)
        else $error("sleep cut trim short");
    a_no_trim_asleep: assert property (@(posedge clk_sys)
        disable iff (reset)
        (state_ff == TR_OFF) |=> state_ff != TR_RUN)
        else $error("trim started while asleep");
    a_hold_off: assert property (@(posedge clk_sys) disable iff (reset)
        (state_ff == TR_WAIT) && sleep_s |=> $stable(dly_ff))
        else $error("power up delay ran asleep");
    a_range_norm: assert property (@(posedge clk_sys) disable iff (reset)
        !ext_s && fs_s ##1 !ext_s |-> range_mv == `FS_HIGH_MV)
        else $error("wrong normal range");
    a_range_ext: assert property (@(posedge clk_sys) disable iff (reset)
        ext_s ##1 ext_s |-> range_mv >= `FS_EXT_MIN_MV &&
        range_mv <= `FS_EXT_MAX_MV)
        else $error("extended range out of bounds");
    a_half_ddr: assert property (@(posedge clk_sys) disable iff (reset)
        demux_half |-> ddr_mode)
        else $error("1:2 outside ddr");
    a_edge_sdr: assert property (@(posedge clk_sys) disable iff (reset)
        launch_rise |-> !ddr_mode)
        else $error("edge select in ddr");
    a_link_off: assert property (@(posedge clk_link) disable iff (reset)
        l_sleep |=> !link_oe)
        else $error("outputs driven asleep");
    c_trim_run: cover property (@(posedge clk_sys) disable iff (reset)
        state_ff == TR_IDLE ##1 state_ff == TR_RUN);
    c_sleep: cover property (@(posedge clk_sys) disable iff (reset)
        state_ff == TR_OFF);
    c_half: cover property (@(posedge clk_link) disable iff (reset)
        l_half);
endmodule
`default_nettype wire

// >>> lane_sink_model.sv
// downstream capture model: feeds core samples, checks lane words
`timescale 1ns/1ps
`default_nettype none
module lane_sink_model (
    // link side
    input  wire logic        clk_link,
    input  wire logic        reset,
    input  wire logic        check_en,
    input  wire logic        demux_half,
    input  wire logic        link_oe,
    input  wire logic [7:0]  lane_a,
    input  wire logic [7:0]  lane_b,
    input  wire logic [7:0]  lane_c,
    input  wire logic [7:0]  lane_d,
    input  wire logic        source_sync_clock,
    // core samples
    output var  logic [7:0]  rise_edge_core,
    output var  logic [7:0]  fall_edge_core,
    // results
    output var  logic [15:0] err_count,
    output var  logic [15:0] word_count,
    output var  logic [15:0] toggle_count,
    output var  logic [15:0] rise_count
);
    logic [6:0] smp_ff;
    logic [7:0] last_d_ff;
    logic       last_clk_ff;
    logic [6:0] lat;
    logic       bad;

    // =========================================
    // sample source: rise sample even, fall odd
    assign rise_edge_core = {smp_ff, 1'b0};
    // fall word at a rising edge was taken half a cycle before it
    assign fall_edge_core = {smp_ff - 7'd1, 1'b1};
    assign lat = smp_ff - lane_d[7:1];
    // lanes a and b are ignored in half mode
    assign bad = (lane_d !== lane_c + 8'h01) || lat < 7'd13 || lat > 7'd16 ||
        (!demux_half && (lane_b !== lane_a + 8'h01 ||
        lane_c !== lane_a + 8'h02));

    always_ff @(posedge clk_link or posedge reset) begin
        if (reset) begin
            smp_ff <= '0;
        end else begin
            smp_ff <= smp_ff + 7'd1;
        end
    end

    // =========================================
    // capture: lane words are not counted or checked while link_oe is low
    always_ff @(posedge clk_link or posedge reset) begin
        if (reset) begin
            last_d_ff    <= '0;
            last_clk_ff  <= 1'b0;
            err_count    <= '0;
            word_count   <= '0;
            toggle_count <= '0;
            rise_count   <= '0;
        end else begin
            last_d_ff   <= lane_d;
            last_clk_ff <= source_sync_clock;
            if (check_en && link_oe && lane_d !== last_d_ff) begin
                word_count <= word_count + 16'h0001;
                if (source_sync_clock && !last_clk_ff) begin
                    rise_count <= rise_count + 16'h0001;
                end
                if (bad) begin
                    err_count <= err_count + 16'h0001;
                end
            end
            if (check_en && source_sync_clock !== last_clk_ff) begin
                toggle_count <= toggle_count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// >>> test_conv_ctrl.sv
// self-checking bench for the converter control and demux block
`timescale 1ns/1ps
`default_nettype none
module test_conv_ctrl;
    import conv_pkg::*;
    logic        clk_sys = 0;
    logic        clk_link = 0;
    logic        reset = 1;
    logic        ext_mode = 0;
    logic        full_scale_select = 0;
    logic        output_swing_select = 0;
    pin3_t       launch_edge_select = EDGE_FLOAT;
    logic        sleep_request = 1;
    logic        trim_request_n = 1;
    logic [15:0] cfg_word = '0;
    logic [9:0]  ext_fs_mv = 10'h2bc;
    logic        rise_over = 0;
    logic        rise_under = 0;
    logic        fall_over = 0;
    logic        fall_under = 0;
    logic        check_en = 0;
    logic [7:0]  rise_edge_core, fall_edge_core;
    logic [7:0]  lane_a, lane_b, lane_c, lane_d;
    logic [9:0]  range_mv;
    logic [5:0]  sample_phase;
    logic        trim_active, swing_high, ddr_mode, demux_half, launch_rise;
    logic        out_range, source_sync_clock, link_oe;
    logic [15:0] err_count, word_count, toggle_count, rise_count;
    int          fail_count = 0;
    int          checks_done = 0;
    int          n;

    always #50 clk_sys = ~clk_sys;
    // offset start keeps the link edges clear of the system edges
    initial begin
        #1.7;
        forever #3 clk_link = ~clk_link;
    end

    conv_ctrl dut_u (.clk_sys(clk_sys), .reset(reset), .ext_mode(ext_mode),
        .full_scale_select(full_scale_select),
        .output_swing_select(output_swing_select),
        .launch_edge_select(launch_edge_select), .sleep_request(sleep_request),
        .trim_request_n(trim_request_n), .cfg_word(cfg_word),
        .ext_fs_mv(ext_fs_mv), .clk_link(clk_link),
        .rise_edge_core(rise_edge_core), .fall_edge_core(fall_edge_core),
        .rise_over(rise_over), .rise_under(rise_under), .fall_over(fall_over),
        .fall_under(fall_under), .trim_active(trim_active),
        .range_mv(range_mv), .swing_high(swing_high), .ddr_mode(ddr_mode),
        .demux_half(demux_half), .launch_rise(launch_rise),
        .sample_phase(sample_phase), .lane_a(lane_a), .lane_b(lane_b),
        .lane_c(lane_c), .lane_d(lane_d), .out_range(out_range),
        .source_sync_clock(source_sync_clock), .link_oe(link_oe));

    lane_sink_model sink_u (.clk_link(clk_link), .reset(reset),
        .check_en(check_en), .demux_half(demux_half), .link_oe(link_oe),
        .lane_a(lane_a), .lane_b(lane_b), .lane_c(lane_c), .lane_d(lane_d),
        .source_sync_clock(source_sync_clock),
        .rise_edge_core(rise_edge_core), .fall_edge_core(fall_edge_core),
        .err_count(err_count), .word_count(word_count),
        .toggle_count(toggle_count), .rise_count(rise_count));

    // =========================================
    // helpers
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #5;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string m);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp,
                           input string m);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask
    task automatic final_report();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic wait_trim(input logic lvl, input int lim);
        n = 0;
        while (trim_active !== lvl && n < lim) begin
            tick(1);
            n++;
        end
        if (n >= lim) begin
            fail_count++;
            $display("wrong value at %0t: trim wait ran out", $time);
            final_report();
        end
    endtask
    task automatic trim_req();
        trim_request_n = 0;
        tick(82);
        trim_request_n = 1;
        tick(82);
    endtask

    // =========================================
    // scenarios
    task automatic t_powerup();
        tick(300);
        chk_bit(trim_active, 1'b0, "trim ran while asleep");
        chk_bit(link_oe, 1'b0, "lanes driven while asleep");
        sleep_request = 0;
        wait_trim(1'b1, 400);
        wait_trim(1'b0, 400);
        chk_val(16'(n), 16'd200, "power-up trim length");
        $display("test powerup done");
    endtask
    task automatic t_settings();
        full_scale_select = 1;
        tick(4);
        chk_val(16'(range_mv), 16'd800, "range high");
        full_scale_select = 0;
        launch_edge_select = EDGE_HIGH;
        tick(4);
        chk_val(16'(range_mv), 16'd600, "range low");
        chk_bit(ddr_mode, 1'b0, "sdr on driven pin");
        chk_bit(launch_rise, 1'b1, "edge high");
        launch_edge_select = EDGE_LOW;
        output_swing_select = 1;
        tick(4);
        chk_bit(launch_rise, 1'b0, "edge low");
        chk_bit(swing_high, 1'b1, "swing pin");
        launch_edge_select = EDGE_FLOAT;
        ext_mode = 1;
        cfg_word = 16'h0500;
        full_scale_select = 1;
        tick(4);
        chk_val(16'(range_mv), 16'd700, "ext range");
        chk_bit(swing_high, 1'b0, "ext swing");
        chk_bit(ddr_mode, 1'b0, "ext sdr");
        chk_bit(launch_rise, 1'b1, "bit 8 as edge");
        chk_bit(demux_half, 1'b0, "no half in sdr");
        ext_fs_mv = 10'h384;
        cfg_word = 16'h0400;
        tick(4);
        chk_val(16'(range_mv), 16'd840, "ext range top");
        chk_bit(launch_rise, 1'b0, "bit 8 clear edge");
        ext_fs_mv = 10'h1f4;
        cfg_word = 16'h0000;
        tick(4);
        chk_val(16'(range_mv), 16'd560, "ext range bottom");
        chk_bit(demux_half, 1'b0, "default quarter");
        ext_mode = 0;
        tick(4);
        chk_bit(ddr_mode, 1'b1, "floating pin ddr");
        $display("test settings done");
    endtask
    task automatic t_lanes(input logic half, input pin3_t edge_pin);
        logic [5:0]  p0;
        logic [15:0] w0;
        logic [15:0] t0;
        logic [15:0] r0;
        ext_mode = half;
        launch_edge_select = edge_pin;
        cfg_word = half ? 16'h0100 : 16'h0000;
        tick(6);
        chk_bit(demux_half, half, "demux ratio");
        chk_bit(ddr_mode, half || edge_pin == EDGE_FLOAT, "ddr");
        chk_bit(link_oe, 1'b1, "lanes driven awake");
        p0 = sample_phase;
        w0 = word_count;
        t0 = toggle_count;
        r0 = rise_count;
        check_en = 1;
        // odd count: the phase dither returns every second cycle
        tick(21);
        check_en = 0;
        chk_val(err_count, 16'h0000, "lane order or latency");
        chk_bit(word_count - w0 > 16'd50, 1'b1, "lane words");
        chk_bit(toggle_count - t0 > 16'd50, 1'b1, "link clock");
        chk_bit(sample_phase !== p0, 1'b1, "phase trim");
        if (edge_pin == EDGE_HIGH)
            chk_val(rise_count - r0, word_count - w0, "rise launch");
        else if (edge_pin == EDGE_LOW)
            chk_val(rise_count - r0, 16'h0000, "fall launch");
        rise_over = 1;
        tick(2);
        chk_bit(out_range, 1'b1, "over flag");
        chk_val(16'(lane_c), 16'h00ff, "rise over code");
        rise_over = 0;
        rise_under = 1;
        tick(2);
        chk_bit(out_range, 1'b1, "rise under flag");
        chk_val(16'(lane_c), 16'h0000, "rise under code");
        rise_under = 0;
        fall_over = 1;
        tick(2);
        chk_bit(out_range, 1'b1, "fall over flag");
        chk_val(16'(lane_d), 16'h00ff, "fall over code");
        fall_over = 0;
        fall_under = 1;
        tick(2);
        chk_bit(out_range, 1'b1, "under flag");
        chk_val(16'(lane_d), 16'h0000, "fall under code");
        fall_under = 0;
        tick(2);
        chk_bit(out_range, 1'b0, "flag clear");
        ext_mode = 0;
        $display("test lanes done");
    endtask
    task automatic t_trim_sleep();
        int seen;
        trim_req();
        wait_trim(1'b1, 20);
        sleep_request = 1;
        tick(10);
        chk_bit(trim_active, 1'b1, "trim cut by sleep");
        chk_bit(link_oe, 1'b1, "sleep before trim end");
        wait_trim(1'b0, 250);
        tick(2);
        chk_bit(link_oe, 1'b0, "sleep after trim");
        trim_req();
        sleep_request = 0;
        seen = 0;
        repeat (300) begin
            tick(1);
            seen += trim_active;
        end
        chk_val(16'(seen), 16'd0, "trim request kept in sleep");
        chk_bit(link_oe, 1'b1, "awake again");
        trim_req();
        wait_trim(1'b1, 20);
        wait_trim(1'b0, 250);
        chk_val(16'(n), 16'd200, "command trim length");
        $display("test trim_sleep done");
    endtask

    initial begin
        tick(2);
        reset = 0;
        t_powerup();
        t_settings();
        t_lanes(1'b0, EDGE_FLOAT);
        t_lanes(1'b0, EDGE_HIGH);
        t_lanes(1'b0, EDGE_LOW);
        t_lanes(1'b1, EDGE_FLOAT);
        t_trim_sleep();
        final_report();
    end
endmodule
`default_nettype wire
